// ---- hdl/olcs_ctrl.sv ----
`include "olcs_defs.svh"

// How it works
// (RQ1) Open load flagged when load current is under the ratio's threshold.
// (RQ2) Open load pulls fault pin low and sets the flag; channel stays on.
// (RQ3) Fault pin recovers once cause gone; latched flag stays until cleared.
// (RQ4) High ratio: open-load check runs continuously while the channel is on.
// (RQ5) High ratio: fault register read while off clears the flag.
// (RQ6) High ratio: read while on clears the flag only if load reconnected.
// (RQ7) Low ratio: periodic check, only with fast slew rate selected.
// (RQ8) Internal PWM, low ratio: checks every 150 ms, also at full duty.
// (RQ9) Internal PWM: check at first turn-off 150 ms after previous check; code checks at the first on cycle once 150 ms have elapsed.
// (RQ10) Direct input, low ratio: check at each turn-off; none at full duty.
// (RQ11) Channel config bit 5 set makes the channel ignore its direct input.
// (RQ12) Low ratio: flag clears only on read after a fault-free check.
// (RQ13) Two select bits route channel 0, channel 1 or temperature to sense.
// (RQ14) Any over-current window disables sensing and holds strobe high.
// (RQ15) Track-and-hold bit: 0 synchronous (reset), 1 track-and-hold.
// (RQ16) Synchronous: strobe low after settling until switch-off.
// (RQ17) Track-and-hold: at switch-off hold last value, strobe high.
// (RQ18) Source change in track-and-hold: discharge, reacquire; off channel lost.
// (RQ19) Host avoids track-and-hold below 60 Hz switching.
// (RQ20) Ratio bit selects high or low ratio; low also lowers OC thresholds.
// (RQ21) Offset polarity bit 8 of retry register: 1 positive, 0 negative.
// (RQ22) Held value keeps polarity of on time; off-time changes ignored.
// (RQ23) Open-load state, flags and timers kept separately per channel.
module olcs_ctrl
	import olcs_pkg::*;
#(
	parameter int unsigned CHECK_CYCLES =
		`OLCS_CHECK_INTERVAL_MS * `OLCS_CLK_MHZ * 1000
)
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic hready,
	input wire logic [31:0] hwdata,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic [1:0] in_pin,
	input wire logic [1:0] pwm_drive,
	input wire logic [1:0] below_thr_high,
	input wire logic [1:0] below_thr_low,
	input wire logic [1:0] overcurrent_window,
	output logic [1:0] hs_on,
	output logic [1:0] fast_slew,
	output logic [1:0] overcurrent_thr_low,
	output logic fault_status_n,
	output logic sense_valid_strobe_n,
	output olcs_pkg::olcs_sense_t sense
);
	import olcs_pkg::*;

	localparam int unsigned SETTLE_CYCLES =
		(`OLCS_SETTLE_NS * `OLCS_CLK_MHZ + 999) / 1000;
	localparam int unsigned DISCHARGE_CYCLES =
		(`OLCS_DISCHARGE_NS * `OLCS_CLK_MHZ + 999) / 1000;

	logic [1:0] rst_q;
	logic rst_n;
	logic [2:0] gen_cfg;
	olcs_chan_cfg_t chan_cfg [2];
	logic [1:0] ratio_low;
	logic [1:0] offset_polarity;
	logic acc;
	logic a_wr;
	logic [7:0] a_addr;
	logic [1:0] chan_int;
	logic [1:0] next_on;
	logic [1:0] off_evt;
	logic [1:0] uc;
	logic [1:0] hi_live;
	logic [1:0] due;
	logic [1:0] lo_check;
	logic [1:0] fr_rd;
	logic [1:0] flag_set;
	logic [1:0] flag_clr;
	logic [1:0] flag;
	logic [1:0] live;
	logic [1:0] ok_seen;
	logic [23:0] timer [2];
	olcs_src_t src;
	olcs_src_t src_prev;
	logic sel_ch;
	logic sel_is_ch;
	logic sel_on;
	logic src_chg;
	logic any_oc;
	olcs_sense_state_t state;
	olcs_sense_state_t next_state;
	logic [15:0] cnt;
	logic [15:0] next_cnt;
	logic hold_ofp;

	// Reset release is synchronised; assertion stays asynchronous
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			rst_q <= 2'b00;
		else
			rst_q <= {rst_q[0], 1'b1};
	end
	assign rst_n = rst_q[1];

	function automatic logic [31:0] olcs_rd(input logic [7:0] a);
		logic [31:0] d;
		d = 32'h0;
		case (a)
			`OLCS_ADDR_GEN_CFG: d[2:0] = gen_cfg;
			`OLCS_ADDR_CHAN_CFG0, `OLCS_ADDR_CHAN_CFG1:
			begin
				d[`OLCS_CHAN_DIRDIS] = chan_cfg[a[3]].dir_dis;
				d[`OLCS_CHAN_PWM] = chan_cfg[a[3]].pwm_en;
				d[`OLCS_CHAN_FAST] = chan_cfg[a[3]].fast_slew;
			end
			`OLCS_ADDR_OC_CFG0: d[`OLCS_OC_RATIO] = ratio_low[0];
			`OLCS_ADDR_OC_CFG1: d[`OLCS_OC_RATIO] = ratio_low[1];
			`OLCS_ADDR_RETRY0: d[`OLCS_RETRY_OFP] = offset_polarity[0];
			`OLCS_ADDR_RETRY1: d[`OLCS_RETRY_OFP] = offset_polarity[1];
			`OLCS_ADDR_FAULT0:
			begin
				d[`OLCS_FAULT_FLAG] = flag[0];
				d[`OLCS_FAULT_LIVE] = live[0];
			end
			`OLCS_ADDR_FAULT1:
			begin
				d[`OLCS_FAULT_FLAG] = flag[1];
				d[`OLCS_FAULT_LIVE] = live[1];
			end
			`OLCS_ADDR_STATUS:
				d[9:0] = {state, ok_seen, sense_valid_strobe_n, hs_on, 2'b00};
			default: d = 32'h0;
		endcase
		return d;
	endfunction : olcs_rd

	// Zero-wait slave; read data and read side effects land at address edge
	assign acc = hsel & htrans[1] & hready;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			a_wr <= 1'b0;
			a_addr <= 8'h00;
			hrdata <= 32'h0;
		end
		else
		begin
			a_wr <= acc & hwrite;
			a_addr <= haddr[7:0];
			if (acc & ~hwrite)
				hrdata <= olcs_rd(haddr[7:0]);
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			gen_cfg <= `OLCS_GEN_RST; // RQ15
			chan_cfg[0] <= `OLCS_CHAN_RST;
			chan_cfg[1] <= `OLCS_CHAN_RST;
			ratio_low <= {2{`OLCS_RATIO_RST}};
			offset_polarity <= {2{`OLCS_OFP_RST}};
		end
		else if (a_wr)
		begin
			case (a_addr)
				`OLCS_ADDR_GEN_CFG: gen_cfg <= hwdata[2:0]; // RQ13 RQ15
				`OLCS_ADDR_CHAN_CFG0, `OLCS_ADDR_CHAN_CFG1:
					chan_cfg[a_addr[3]] <= {hwdata[`OLCS_CHAN_DIRDIS],
						hwdata[`OLCS_CHAN_PWM], hwdata[`OLCS_CHAN_FAST]};
				`OLCS_ADDR_OC_CFG0: ratio_low[0] <= hwdata[`OLCS_OC_RATIO];
				`OLCS_ADDR_OC_CFG1: ratio_low[1] <= hwdata[`OLCS_OC_RATIO];
				`OLCS_ADDR_RETRY0: offset_polarity[0] <= hwdata[`OLCS_RETRY_OFP]; // RQ21
				`OLCS_ADDR_RETRY1: offset_polarity[1] <= hwdata[`OLCS_RETRY_OFP];
				default: ;
			endcase
		end
	end

	// Each channel owns its own detector, timer and flags
	for (genvar c = 0; c < 2; c++)
	begin : g_ch // RQ23
		localparam logic [7:0] FAULT_ADDR =
			(c == 0) ? `OLCS_ADDR_FAULT0 : `OLCS_ADDR_FAULT1;

		assign chan_int[c] = chan_cfg[c].dir_dis | chan_cfg[c].pwm_en; // RQ11
		assign next_on[c] = chan_int[c] ? pwm_drive[c] : in_pin[c];
		assign off_evt[c] = hs_on[c] & ~next_on[c];
		assign uc[c] = ratio_low[c] ? below_thr_low[c] : below_thr_high[c]; // RQ1
		assign hi_live[c] = ~ratio_low[c] & hs_on[c] & uc[c]; // RQ4
		assign due[c] = timer[c] >= 24'(CHECK_CYCLES - 1);
		// Internal PWM waits for the interval; full duty checks while on.
		// This check replaces the turn-off check that direct input uses.
		assign lo_check[c] = ratio_low[c] & chan_cfg[c].fast_slew // RQ7
			& (chan_int[c] ? due[c] & hs_on[c] // RQ8 RQ9
			: off_evt[c]); // RQ10
		assign fr_rd[c] = acc & ~hwrite & (haddr[7:0] == FAULT_ADDR);
		assign flag_set[c] = hi_live[c] | (lo_check[c] & uc[c]); // RQ2
		assign flag_clr[c] = fr_rd[c] & (ratio_low[c] ? ok_seen[c] // RQ12
			: (~hs_on[c] | ~uc[c])); // RQ5 RQ6

		always_ff @(posedge clk or negedge rst_n)
		begin
			if (!rst_n)
			begin
				hs_on[c] <= 1'b0;
				flag[c] <= 1'b0;
				live[c] <= 1'b0;
				ok_seen[c] <= 1'b0;
				timer[c] <= 24'h0;
			end
			else
			begin
				hs_on[c] <= next_on[c];
				// A new fault wins over a clearing read in the same cycle
				flag[c] <= flag_set[c] | (flag[c] & ~flag_clr[c]);
				if (~ratio_low[c])
					live[c] <= hi_live[c]; // RQ3
				else if (lo_check[c])
					live[c] <= uc[c]; // RQ3
				if (lo_check[c])
					ok_seen[c] <= ~uc[c];
				else if (flag_clr[c])
					ok_seen[c] <= 1'b0;
				if (lo_check[c])
					timer[c] <= 24'h0;
				else if (~due[c])
					timer[c] <= timer[c] + 24'h1;
			end
		end

		AST_FLAG_SET: assert property (@(posedge clk) disable iff (!rst_n)
			hi_live[c] |=> flag[c] && !fault_status_n) // RQ2
			else $error("open load did not raise flag and pin");
		AST_PIN_RECOVER: assert property (@(posedge clk) disable iff (!rst_n)
			!ratio_low[c] && !(hs_on[c] && uc[c]) |=> !live[c]) // RQ3
			else $error("fault pin term did not recover");
		AST_OFF_READ_CLR: assert property (@(posedge clk) disable iff (!rst_n)
			fr_rd[c] && !ratio_low[c] && !hs_on[c] |=> !flag[c]) // RQ5
			else $error("read while off did not clear flag");
		AST_ON_READ_KEEP: assert property (@(posedge clk) disable iff (!rst_n)
			fr_rd[c] && !ratio_low[c] && hs_on[c] && uc[c] |=> flag[c]) // RQ6
			else $error("read cleared flag with load still open");
		AST_SLOW_NO_CHECK: assert property (@(posedge clk)
			disable iff (!rst_n)
			ratio_low[c] && !chan_cfg[c].fast_slew && !flag[c]
			|=> !flag[c]) // RQ7
			else $error("low ratio check ran with slow slew");
		AST_INTERVAL: assert property (@(posedge clk) disable iff (!rst_n)
			lo_check[c] && chan_int[c]
			|-> timer[c] == 24'(CHECK_CYCLES - 1)) // RQ9
			else $error("periodic check before interval elapsed");
		AST_FULL_DUTY: assert property (@(posedge clk) disable iff (!rst_n)
			ratio_low[c] && !chan_int[c] && hs_on[c] && next_on[c]
			|-> !lo_check[c]) // RQ10
			else $error("direct input check without turn-off");
		AST_LO_CLEAR: assert property (@(posedge clk) disable iff (!rst_n)
			ratio_low[c] && fr_rd[c] && !ok_seen[c] && flag[c]
			|=> flag[c]) // RQ12
			else $error("low ratio flag cleared without clean check");
	end

	assign fault_status_n = ~|live; // RQ2 RQ3
	assign fast_slew = {chan_cfg[1].fast_slew, chan_cfg[0].fast_slew};
	assign overcurrent_thr_low = ratio_low; // RQ20

	// Both bits equal means temperature
	assign src = (gen_cfg[`OLCS_GEN_SNS0] == gen_cfg[`OLCS_GEN_SNS1])
		? OLCS_SRC_TEMP
		: (gen_cfg[`OLCS_GEN_SNS1] ? OLCS_SRC_CH1 : OLCS_SRC_CH0); // RQ13
	assign sel_ch = (src == OLCS_SRC_CH1);
	assign sel_is_ch = (src != OLCS_SRC_TEMP);
	assign sel_on = sel_is_ch & hs_on[sel_ch];
	assign src_chg = (src != src_prev);
	assign any_oc = |overcurrent_window;

	always_comb
	begin
		next_state = state;
		next_cnt = 16'h0;
		if (src_chg & gen_cfg[`OLCS_GEN_TH] & sel_is_ch)
			next_state = SNS_DISCHARGE; // RQ18
		else if (any_oc | ~sel_is_ch)
			next_state = SNS_IDLE; // RQ14
		else if (src_chg)
			next_state = sel_on ? SNS_SETTLE : SNS_IDLE;
		else
		begin
			case (state)
				SNS_IDLE:
					if (sel_on)
						next_state = SNS_SETTLE;
				SNS_SETTLE:
					if (!sel_on)
						next_state = SNS_IDLE;
					else if (cnt == 16'(SETTLE_CYCLES - 1))
						next_state = SNS_VALID; // RQ16
					else
						next_cnt = cnt + 16'h1;
				SNS_VALID:
					if (!sel_on)
						next_state = gen_cfg[`OLCS_GEN_TH]
							? SNS_HOLD : SNS_IDLE; // RQ16 RQ17
				SNS_HOLD:
					if (sel_on)
						next_state = SNS_SETTLE;
				SNS_DISCHARGE:
					// A channel that is off now has nothing to reacquire
					if (cnt == 16'(DISCHARGE_CYCLES - 1))
						next_state = sel_on ? SNS_SETTLE : SNS_IDLE; // RQ18
					else
						next_cnt = cnt + 16'h1;
				default: next_state = SNS_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state <= SNS_IDLE;
			cnt <= 16'h0;
			src_prev <= OLCS_SRC_TEMP;
			hold_ofp <= 1'b0;
		end
		else
		begin
			state <= next_state;
			cnt <= next_cnt;
			src_prev <= src;
			if (state == SNS_VALID && next_state == SNS_HOLD)
				hold_ofp <= offset_polarity[sel_ch]; // RQ22
		end
	end

	assign sense_valid_strobe_n = (state != SNS_VALID) | any_oc; // RQ14 RQ16
	assign sense.src = src;
	assign sense.enable = ~any_oc
		& (~sel_is_ch | sel_on | state == SNS_HOLD); // RQ14 RQ16
	assign sense.hold = (state == SNS_HOLD); // RQ17
	assign sense.discharge = (state == SNS_DISCHARGE); // RQ18
	assign sense.offset_pos = (state == SNS_HOLD)
		? hold_ofp : offset_polarity[sel_ch]; // RQ21 RQ22

	AST_OC_STROBE: assert property (@(posedge clk) disable iff (!rst_n)
		any_oc |-> sense_valid_strobe_n && !sense.enable) // RQ14
		else $error("sensing active during over-current window");
	AST_SETTLE: assert property (@(posedge clk) disable iff (!rst_n)
		$fell(sense_valid_strobe_n) |-> $past(state) == SNS_SETTLE
		&& $past(cnt) == 16'(SETTLE_CYCLES - 1)) // RQ16
		else $error("strobe fell without full settling");
	AST_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
		state == SNS_VALID && gen_cfg[`OLCS_GEN_TH] && !sel_on && !any_oc
		&& !src_chg |=> sense.hold && sense_valid_strobe_n) // RQ17
		else $error("switch-off did not hold the sense value");
	AST_HOLD_POL: assert property (@(posedge clk) disable iff (!rst_n)
		state == SNS_HOLD && $past(state) == SNS_HOLD
		|-> $stable(sense.offset_pos)) // RQ22
		else $error("held polarity changed while off");
	AST_DISCHARGE: assert property (@(posedge clk) disable iff (!rst_n)
		src_chg && gen_cfg[`OLCS_GEN_TH] && sel_is_ch
		|=> sense.discharge) // RQ18
		else $error("source change did not discharge hold");
endmodule : olcs_ctrl

// ---- hdl/olcs_defs.svh ----
`ifndef OLCS_DEFS_SVH
`define OLCS_DEFS_SVH

// Register byte offsets
`define OLCS_ADDR_GEN_CFG 8'h00
`define OLCS_ADDR_CHAN_CFG0 8'h04
`define OLCS_ADDR_CHAN_CFG1 8'h08
`define OLCS_ADDR_OC_CFG0 8'h0c
`define OLCS_ADDR_OC_CFG1 8'h10
`define OLCS_ADDR_RETRY0 8'h14
`define OLCS_ADDR_RETRY1 8'h18
`define OLCS_ADDR_FAULT0 8'h1c
`define OLCS_ADDR_FAULT1 8'h20
`define OLCS_ADDR_STATUS 8'h24

// Field positions
`define OLCS_GEN_SNS0 0
`define OLCS_GEN_SNS1 1
`define OLCS_GEN_TH 2
`define OLCS_CHAN_PWM 0
`define OLCS_CHAN_FAST 1
`define OLCS_CHAN_DIRDIS 5
`define OLCS_OC_RATIO 0
`define OLCS_RETRY_OFP 8
`define OLCS_FAULT_FLAG 0
`define OLCS_FAULT_LIVE 1

// Reset values
`define OLCS_GEN_RST 3'h0
`define OLCS_CHAN_RST 3'h0
`define OLCS_RATIO_RST 1'b0
`define OLCS_OFP_RST 1'b0

// Timing
`define OLCS_CLK_MHZ 100
`define OLCS_CHECK_INTERVAL_MS 150
`define OLCS_SETTLE_NS 2000
`define OLCS_DISCHARGE_NS 500

`endif

// ---- hdl/olcs_pkg.sv ----
package olcs_pkg;
	typedef struct packed {
		logic dir_dis;
		logic pwm_en;
		logic fast_slew;
	} olcs_chan_cfg_t;

	typedef enum logic [1:0] {OLCS_SRC_CH0, OLCS_SRC_CH1, OLCS_SRC_TEMP}
		olcs_src_t;

	typedef enum logic [2:0] {SNS_IDLE, SNS_SETTLE, SNS_VALID, SNS_HOLD,
		SNS_DISCHARGE} olcs_sense_state_t;

	typedef struct packed {
		olcs_src_t src;
		logic enable;
		logic hold;
		logic discharge;
		logic offset_pos;
	} olcs_sense_t;
endpackage : olcs_pkg

// ---- sim/olcs_load_model.sv ----
module olcs_load_model
(
	input wire logic [1:0] hs_on,
	input wire logic [1:0] open_load,
	output logic [1:0] below_thr_high,
	output logic [1:0] below_thr_low
);
	timeunit 1ns;
	timeprecision 1ps;
	// An off channel carries no load current, so both comparators trip
	assign below_thr_high = open_load | ~hs_on;
	assign below_thr_low = open_load | ~hs_on;
endmodule : olcs_load_model

// ---- sim/olcs_ctrl_tb_top.sv ----
`include "olcs_defs.svh"
module olcs_ctrl_tb_top;
	import olcs_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, nrst, hsel, hwrite, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata, got, lfsr;
	logic [1:0] htrans, in_pin, pwm_drive, below_thr_high, below_thr_low;
	logic [1:0] overcurrent_window, hs_on, fast_slew, open_load;
	logic [1:0] overcurrent_thr_low;
	logic [2:0] hsize;
	logic fault_status_n, sense_valid_strobe_n;
	olcs_sense_t sense;
	olcs_src_t src_tab [3] = '{OLCS_SRC_CH0, OLCS_SRC_CH1, OLCS_SRC_TEMP};
	logic [31:0] exp_q [$];
	int miscompares, checked;
	event rd_ev;

	olcs_ctrl #(.CHECK_CYCLES(20)) olcs_ctrl_i (.clk(clk), .nrst(nrst),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.in_pin(in_pin), .pwm_drive(pwm_drive),
		.below_thr_high(below_thr_high), .below_thr_low(below_thr_low),
		.overcurrent_window(overcurrent_window), .hs_on(hs_on),
		.fast_slew(fast_slew), .overcurrent_thr_low(overcurrent_thr_low),
		.fault_status_n(fault_status_n),
		.sense_valid_strobe_n(sense_valid_strobe_n), .sense(sense));

	olcs_load_model olcs_load_model_i (.hs_on(hs_on), .open_load(open_load),
		.below_thr_high(below_thr_high), .below_thr_low(below_thr_low));

	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr_next

	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : complete_run

	task automatic chk_reg(input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e)
		begin
			miscompares++;
			$display("[ERR] %0t read got %h want %h", $time, g, e);
		end
	endtask : chk_reg

	task automatic chk_pin(input logic g, input logic e);
		checked++;
		if (g !== e)
		begin
			miscompares++;
			$display("[ERR] %0t pin got %b want %b", $time, g, e);
		end
	endtask : chk_pin

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask : cyc

	// Master holds each phase until hready is seen high at an edge
	task automatic bus(input logic [7:0] a, input logic w,
		input logic [31:0] d);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		do @(posedge clk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hreadyout !== 1'b1);
	endtask : bus

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(a, 1'b1, d);
		cyc(1);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		bus(a, 1'b0, 32'h0);
		got = hrdata;
		->rd_ev;
	endtask : rd

	initial
	begin
		forever
		begin
			@(rd_ev);
			chk_reg(got, exp_q.pop_front());
		end
	end

	initial
	begin
		cyc(20000);
		miscompares++;
		complete_run();
	end

	initial
	begin
		{nrst, hsel, hwrite, htrans, haddr, hwdata} = '0;
		{in_pin, pwm_drive, overcurrent_window, open_load} = '0;
		hsize = 3'h2;
		lfsr = 32'h129563c8;
		cyc(16);
		nrst <= 1'b1;
		cyc(4);
		rd(`OLCS_ADDR_GEN_CFG, 32'h0);
		chk_pin(hresp, 1'b0);
		lfsr = lfsr_next(lfsr);
		wr(8'h3c, lfsr);
		rd(8'h3c, 32'h0);
		$display("test registers done");
		in_pin <= 2'b01;
		open_load <= 2'b01;
		cyc(4);
		chk_pin(fault_status_n, 1'b0);
		chk_pin(hs_on[0], 1'b1);
		rd(`OLCS_ADDR_FAULT0, 32'h3);
		rd(`OLCS_ADDR_FAULT0, 32'h3);
		in_pin <= 2'b00;
		cyc(3);
		rd(`OLCS_ADDR_FAULT0, 32'h1);
		rd(`OLCS_ADDR_FAULT0, 32'h0);
		in_pin <= 2'b01;
		cyc(3);
		open_load <= 2'b00;
		cyc(2);
		chk_pin(fault_status_n, 1'b1);
		rd(`OLCS_ADDR_FAULT0, 32'h1);
		rd(`OLCS_ADDR_FAULT0, 32'h0);
		in_pin <= 2'b00;
		$display("test high ratio done");
		wr(`OLCS_ADDR_OC_CFG1, 32'h1);
		chk_pin(overcurrent_thr_low[1], 1'b1);
		in_pin <= 2'b10;
		open_load <= 2'b10;
		cyc(3);
		in_pin <= 2'b00;
		cyc(3);
		rd(`OLCS_ADDR_FAULT1, 32'h0);
		wr(`OLCS_ADDR_CHAN_CFG1, 32'h2);
		chk_pin(fast_slew[1], 1'b1);
		in_pin <= 2'b10;
		cyc(4);
		chk_pin(fault_status_n, 1'b1);
		in_pin <= 2'b00;
		cyc(3);
		chk_pin(fault_status_n, 1'b0);
		rd(`OLCS_ADDR_FAULT1, 32'h3);
		rd(`OLCS_ADDR_FAULT1, 32'h3);
		open_load <= 2'b00;
		in_pin <= 2'b10;
		cyc(3);
		in_pin <= 2'b00;
		cyc(3);
		rd(`OLCS_ADDR_FAULT1, 32'h1);
		rd(`OLCS_ADDR_FAULT1, 32'h0);
		open_load <= 2'b10;
		in_pin <= 2'b10;
		cyc(40);
		rd(`OLCS_ADDR_FAULT1, 32'h0);
		open_load <= 2'b00;
		cyc(2);
		in_pin <= 2'b00;
		wr(`OLCS_ADDR_CHAN_CFG1, 32'h20);
		in_pin <= 2'b10;
		cyc(3);
		chk_pin(hs_on[1], 1'b0);
		pwm_drive <= 2'b10;
		cyc(3);
		chk_pin(hs_on[1], 1'b1);
		{pwm_drive, in_pin} <= '0;
		$display("test direct low ratio done");
		wr(`OLCS_ADDR_OC_CFG0, 32'h1);
		wr(`OLCS_ADDR_CHAN_CFG0, 32'h3);
		open_load <= 2'b01;
		pwm_drive <= 2'b01;
		cyc(3);
		open_load <= 2'b00;
		cyc(3);
		rd(`OLCS_ADDR_FAULT0, 32'h3);
		rd(`OLCS_ADDR_FAULT1, 32'h0);
		rd(`OLCS_ADDR_FAULT0, 32'h3);
		cyc(30);
		rd(`OLCS_ADDR_FAULT0, 32'h1);
		rd(`OLCS_ADDR_FAULT0, 32'h0);
		pwm_drive <= 2'b00;
		wr(`OLCS_ADDR_CHAN_CFG0, 32'h0);
		$display("test internal pwm done");
		for (int i = 0; i < 3; i++)
		begin
			wr(`OLCS_ADDR_GEN_CFG, 32'(i + 1));
			chk_pin(sense.src === src_tab[i], 1'b1);
		end
		wr(`OLCS_ADDR_GEN_CFG, 32'h1);
		in_pin <= 2'b01;
		cyc(100);
		chk_pin(sense_valid_strobe_n, 1'b1);
		cyc(110);
		chk_pin(sense_valid_strobe_n, 1'b0);
		chk_pin(sense.offset_pos, 1'b0);
		overcurrent_window <= 2'b10;
		cyc(1);
		chk_pin(sense_valid_strobe_n, 1'b1);
		chk_pin(sense.enable, 1'b0);
		overcurrent_window <= 2'b00;
		cyc(210);
		in_pin <= 2'b00;
		cyc(3);
		chk_pin(sense_valid_strobe_n, 1'b1);
		chk_pin(sense.hold, 1'b0);
		wr(`OLCS_ADDR_RETRY0, 32'h100);
		// On time stays short, well above the slowest usable hold rate
		wr(`OLCS_ADDR_GEN_CFG, 32'h5);
		in_pin <= 2'b01;
		cyc(210);
		chk_pin(sense_valid_strobe_n, 1'b0);
		chk_pin(sense.offset_pos, 1'b1);
		in_pin <= 2'b00;
		cyc(3);
		chk_pin(sense_valid_strobe_n, 1'b1);
		chk_pin(sense.hold, 1'b1);
		wr(`OLCS_ADDR_RETRY0, 32'h0);
		chk_pin(sense.offset_pos, 1'b1);
		wr(`OLCS_ADDR_GEN_CFG, 32'h6);
		// Source change is seen one cycle after the select bits land
		cyc(1);
		chk_pin(sense.discharge, 1'b1);
		cyc(60);
		chk_pin(sense.hold, 1'b0);
		chk_pin(sense_valid_strobe_n, 1'b1);
		$display("test sensing done");
		cyc(4);
		if (exp_q.size() != 0)
			miscompares++;
		complete_run();
	end
endmodule : olcs_ctrl_tb_top
